// File: rtl/qps_sequencer.sv
// qps_sequencer: phase generator and two-stage fetch/execute sequencer
`timescale 1ns/10ps
// Functional notes
// - divide input clock by four into four non-overlapping phases in order
// - program counter increments in the first phase of every cycle except the first after clear or jump
// - fetched program word captured at the fourth phase of fetch
// - instruction register valid from first phase, executed phases two-four
// - four phases per cycle; fetch overlaps previous instruction's execute
// - program counter change takes two cycles; prefetched word discarded
// - data memory operand read in the second phase of execute
// - data memory destination write in the fourth phase of execute
// - in RC mode drive clock out at one quarter of input rate
// - low master clear holds the device in reset
module qps_sequencer #(
  parameter int unsigned PC_W = qps_pkg::QPS_PC_W
) (
  // clock, reset, enable
  input  wire logic                            i_clock,
  input  wire logic                            i_rst_n,
  input  wire logic                            i_clk_en,
  // master clear and oscillator mode
  input  wire logic                            i_master_clear_n,
  input  wire logic                            i_rc_mode,
  // program memory
  input  wire logic [qps_pkg::QPS_INSTR_W-1:0] i_prog_data,
  output logic      [PC_W-1:0]                 o_prog_addr,
  // execute answer
  input  wire qps_pkg::qps_exec_t              i_exec,
  // instruction register and phase strobes
  output logic      [qps_pkg::QPS_INSTR_W-1:0] o_instr,
  output logic                                 o_instr_valid,
  output qps_pkg::qps_phases_t                 o_phases,
  // data memory strobes
  output qps_pkg::qps_dmem_t                   o_dmem,
  // clock out pin and its enable
  output logic                                 o_osc_out_div4_clock,
  output logic                                 o_osc_out_div4_clock_oe
);
  import qps_pkg::*;

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  // jump target and counter share one width; nothing else is served
  if (PC_W != QPS_PC_W) begin : g_bad_pc_w
    $error("qps_sequencer: PC_W must equal QPS_PC_W");
  end

  // ---------------------------------------------------------------
  // phase generator
  // ---------------------------------------------------------------
  qps_phase_t  phase;
  qps_phase_t  next_phase;
  qps_phases_t next_phases;
  logic        next_clkout;
  logic        next_clkout_oe;
  logic        held;

  assign held = !i_master_clear_n;

  // ---------------------------------------------------------------
  // phase next values
  // ---------------------------------------------------------------
  always_comb begin
    next_phase  = phase;
    next_phases = o_phases;
    next_clkout    = o_osc_out_div4_clock;
    // pin driven only in rc mode
    next_clkout_oe = i_rc_mode && !held;
    if (held) begin
      next_phase  = QPS_PH_FOURTH;
      next_phases = '0;
      next_clkout = 1'h0;
    end else begin
      case (phase)
        QPS_PH_FIRST:  next_phase = QPS_PH_SECOND;
        QPS_PH_SECOND: next_phase = QPS_PH_THIRD;
        QPS_PH_THIRD:  next_phase = QPS_PH_FOURTH;
        QPS_PH_FOURTH: next_phase = QPS_PH_FIRST;
        default:       next_phase = QPS_PH_FIRST;
      endcase
      next_phases.phase_first  = (next_phase == QPS_PH_FIRST);
      next_phases.phase_second = (next_phase == QPS_PH_SECOND);
      next_phases.phase_third  = (next_phase == QPS_PH_THIRD);
      next_phases.phase_fourth = (next_phase == QPS_PH_FOURTH);
      // high in phases two and three
      next_clkout = i_rc_mode && (next_phase == QPS_PH_SECOND ||
                                  next_phase == QPS_PH_THIRD);
    end
  end

  // ---------------------------------------------------------------
  // phase and clock out registers
  // ---------------------------------------------------------------
  // reset parks the phase before the first
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      phase                   <= QPS_PH_FOURTH;
      o_phases                <= '0;
      o_osc_out_div4_clock    <= 1'h0;
      o_osc_out_div4_clock_oe <= 1'h0;
    end else if (i_clk_en) begin
      phase                   <= next_phase;
      o_phases                <= next_phases;
      o_osc_out_div4_clock    <= next_clkout;
      o_osc_out_div4_clock_oe <= next_clkout_oe;
    end
  end

  // ---------------------------------------------------------------
  // fetch / execute pipeline
  // ---------------------------------------------------------------
  logic [PC_W-1:0]        next_pc;
  logic [QPS_INSTR_W-1:0] fetch_word;
  logic [QPS_INSTR_W-1:0] next_fetch_word;
  logic                   fetch_valid;
  logic                   next_fetch_valid;
  logic                   fetch_busy;
  logic                   next_fetch_busy;
  logic [QPS_INSTR_W-1:0] next_instr;
  logic                   next_instr_valid;
  qps_dmem_t              next_dmem;

  // ---------------------------------------------------------------
  // pipeline next values
  // ---------------------------------------------------------------
  always_comb begin
    next_pc          = o_prog_addr;
    next_fetch_word  = fetch_word;
    next_fetch_valid = fetch_valid;
    next_fetch_busy  = fetch_busy;
    next_instr       = o_instr;
    next_instr_valid = o_instr_valid;
    next_dmem        = o_dmem;
    next_dmem.rd_en  = 1'b0;
    next_dmem.wr_en  = 1'b0;
    if (held) begin
      next_pc          = QPS_RESET_VECTOR;
      next_fetch_valid = 1'b0;
      next_fetch_busy  = 1'b0;
      next_instr_valid = 1'b0;
      next_instr       = QPS_NOP_WORD;
    end else begin
      case (next_phase)
        QPS_PH_FIRST: begin
          next_instr       = fetch_word;
          next_instr_valid = fetch_valid;
          next_fetch_valid = 1'b0;
          // pc increments, fetch begins
          // no step on the first cycle after clear or jump
          if (fetch_busy) begin
            next_pc = o_prog_addr + QPS_PC_STEP;
          end
          next_fetch_busy = 1'b1;
        end
        QPS_PH_SECOND: begin
          next_dmem.rd_en   = o_instr_valid;
          next_dmem.rd_addr = o_instr[QPS_DADDR_W-1:0];
        end
        QPS_PH_THIRD: begin
          next_dmem.rd_en = 1'b0;
        end
        QPS_PH_FOURTH: begin
          next_dmem.wr_en   = o_instr_valid && i_exec.write_en;
          next_dmem.wr_addr = i_exec.dst_addr;
          next_dmem.wr_data = i_exec.result;
          next_fetch_word  = i_prog_data;
          next_fetch_valid = fetch_busy;
          if (o_instr_valid && i_exec.jump_instruction) begin
            next_pc          = i_exec.target;
            next_fetch_valid = 1'b0;
            next_fetch_busy  = 1'b0;
          end
        end
        default: begin
          next_pc = o_prog_addr;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pipeline registers
  // ---------------------------------------------------------------
  // one instruction per four phases
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_prog_addr   <= QPS_RESET_VECTOR;
      fetch_word    <= QPS_NOP_WORD;
      fetch_valid   <= 1'b0;
      fetch_busy    <= 1'b0;
      o_instr       <= QPS_NOP_WORD;
      o_instr_valid <= 1'b0;
      o_dmem        <= '0;
    end else if (i_clk_en) begin
      o_prog_addr   <= next_pc;
      fetch_word    <= next_fetch_word;
      fetch_valid   <= next_fetch_valid;
      fetch_busy    <= next_fetch_busy;
      o_instr       <= next_instr;
      o_instr_valid <= next_instr_valid;
      o_dmem        <= next_dmem;
    end
  end

endmodule

// File: rtl/qps_pkg.sv
// qps_pkg: constants and types for the quad phase instruction sequencer
package qps_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned QPS_PC_W    = 13;
  localparam int unsigned QPS_INSTR_W = 14;
  localparam int unsigned QPS_DADDR_W = 7;
  localparam int unsigned QPS_DATA_W  = 8;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [QPS_PC_W-1:0]    QPS_RESET_VECTOR = 13'h0000;
  localparam logic [QPS_PC_W-1:0]    QPS_PC_STEP      = 13'h0001;
  localparam logic [QPS_INSTR_W-1:0] QPS_NOP_WORD     = 14'h0000;
  localparam int unsigned QPS_PHASES = 4;

  // ---------------------------------------------------------------
  // phase states, one per rising input clock edge
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    QPS_PH_FIRST  = 2'b00,
    QPS_PH_SECOND = 2'b01,
    QPS_PH_THIRD  = 2'b10,
    QPS_PH_FOURTH = 2'b11
  } qps_phase_t;

  // one-hot phase strobes
  typedef struct packed {
    logic phase_first;
    logic phase_second;
    logic phase_third;
    logic phase_fourth;
  } qps_phases_t;

  // answer from execute logic for the current instruction
  typedef struct packed {
    logic                  jump_instruction;
    logic [QPS_PC_W-1:0]   target;
    logic                  write_en;
    logic [QPS_DADDR_W-1:0] dst_addr;
    logic [QPS_DATA_W-1:0] result;
  } qps_exec_t;

  // data memory strobes
  typedef struct packed {
    logic                   rd_en;
    logic [QPS_DADDR_W-1:0] rd_addr;
    logic                   wr_en;
    logic [QPS_DADDR_W-1:0] wr_addr;
    logic [QPS_DATA_W-1:0]  wr_data;
  } qps_dmem_t;

endpackage

// File: verif/qps_prog_model.sv
// program memory model answering the fetch address
`timescale 1ns/10ps
module qps_prog_model
  import qps_pkg::*;
(
  // fetch address and word
  input  wire logic [QPS_PC_W-1:0]    i_addr,
  output logic      [QPS_INSTR_W-1:0] o_data
);
  assign o_data = {1'b1, i_addr} ^ 14'h02A5;
endmodule

// File: verif/qps_seq_assertions.sv
// assertion checker for the instruction sequencer
`timescale 1ns/10ps
module qps_seq_checker
  import qps_pkg::*;
#(
  parameter int unsigned PC_W = QPS_PC_W
) (
  // clock, reset and controls
  input wire logic                   i_clock,
  input wire logic                   i_rst_n,
  input wire logic                   i_clk_en,
  input wire logic                   i_master_clear_n,
  input wire logic                   i_rc_mode,
  input wire qps_exec_t              i_exec,
  // observed outputs
  input wire logic [PC_W-1:0]        o_prog_addr,
  input wire logic [QPS_INSTR_W-1:0] o_instr,
  input wire logic                   o_instr_valid,
  input wire qps_phases_t            o_phases,
  input wire qps_dmem_t              o_dmem,
  input wire logic                   o_osc_out_div4_clock,
  input wire logic                   o_osc_out_div4_clock_oe
);
  wire run = i_clk_en && i_master_clear_n;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_phase_rotate: assert property (
    run && o_phases != '0 |=>
    o_phases == {$past(o_phases[0]), $past(o_phases[3:1])})
    else $error("phase order broken");
  a_release_first: assert property (
    run && o_phases == '0 |=> o_phases.phase_first)
    else $error("no first phase after clear");
  a_pc_hold: assert property (
    run && (o_phases.phase_first || o_phases.phase_second)
    |=> $stable(o_prog_addr)) else $error("pc moved mid cycle");
  a_instr_hold: assert property (
    run && !o_phases.phase_fourth |=> $stable(o_instr_valid))
    else $error("instruction changed mid cycle");
  a_read_phase: assert property (
    o_dmem.rd_en |-> o_phases.phase_second
    && o_dmem.rd_addr == o_instr[6:0]) else $error("bad operand read");
  a_write_phase: assert property (
    o_dmem.wr_en |-> o_phases.phase_fourth && o_instr_valid)
    else $error("bad destination write");
  a_jump_target: assert property (
    run && o_phases.phase_third && o_instr_valid
    && i_exec.jump_instruction |=> o_prog_addr == $past(i_exec.target)
    ##[1:4] !o_instr_valid) else $error("jump not redirected");
  a_clkout_phase: assert property (
    o_osc_out_div4_clock |-> o_phases.phase_second
    || o_phases.phase_third) else $error("clock out off phase");
  a_clear_idle: assert property (
    !i_master_clear_n && i_clk_en |=> o_phases == '0 && !o_instr_valid)
    else $error("clear not held");
  a_oe_follow: assert property (
    i_clk_en |=> o_osc_out_div4_clock_oe ==
    ($past(i_rc_mode) && $past(i_master_clear_n)))
    else $error("clock out enable wrong");
  a_clkout_high: assert property (
    run && i_rc_mode && (o_phases.phase_first || o_phases.phase_second)
    |=> o_osc_out_div4_clock) else $error("clock out missing");
  c_jump: cover property (o_phases.phase_fourth && !o_instr_valid);
  c_write: cover property (o_dmem.wr_en);
  c_clear: cover property (!i_master_clear_n);
endmodule
bind qps_sequencer qps_seq_checker #(.PC_W(PC_W)) u_chk (.i_clock,
  .i_rst_n, .i_clk_en, .i_master_clear_n, .i_rc_mode, .i_exec,
  .o_prog_addr, .o_instr, .o_instr_valid, .o_phases, .o_dmem,
  .o_osc_out_div4_clock, .o_osc_out_div4_clock_oe);

// File: verif/tb_top.sv
// self-checking bench for the instruction sequencer
`timescale 1ns/10ps
module tb_top;
  import qps_pkg::*;
  logic i_clock, i_rst_n, i_clk_en, i_master_clear_n, i_rc_mode;
  logic [QPS_INSTR_W-1:0] i_prog_data, o_instr, ins, wd;
  logic [QPS_PC_W-1:0]    o_prog_addr, pc;
  logic [14:0]            wx;
  qps_exec_t              i_exec;
  qps_phases_t            o_phases;
  qps_dmem_t              o_dmem;
  logic o_instr_valid, o_osc_out_div4_clock, o_osc_out_div4_clock_oe;
  int num_errors, n_checks, cyc, seed, ph, val, got, clr, ck, oe, wr;
  qps_prog_model u_mem (.i_addr(o_prog_addr), .o_data(i_prog_data));
  qps_sequencer dut (.i_clock, .i_rst_n, .i_clk_en, .i_master_clear_n,
    .i_rc_mode, .i_prog_data, .o_prog_addr, .i_exec, .o_instr,
    .o_instr_valid, .o_phases, .o_dmem, .o_osc_out_div4_clock,
    .o_osc_out_div4_clock_oe);
  initial begin
    i_clock = 0;
    forever #5 i_clock = ~i_clock;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // timeout watchdog
  always @(posedge i_clock) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      test_done();
    end
  end
  // reference pipeline model
  always @(posedge i_clock) begin
    if (!i_rst_n || !i_master_clear_n) begin
      ph = 3; pc = 0; val = 0; got = 0; clr = 1; ck = 0; wr = 0;
    end else if (i_clk_en) begin
      ph = (ph + 1) % QPS_PHASES; clr = 0; wr = 0;
      if (ph == 3) begin
        wr = val && i_exec.write_en;
        wx = {i_exec.dst_addr, i_exec.result};
        if (val && i_exec.jump_instruction) pc = i_exec.target;
        else begin
          wd = {1'b1, pc} ^ 14'h02A5;
          got = 1;
        end
      end
      if (ph == 0) begin
        val = got;
        if (got) begin
          ins = wd;
          pc = pc + 1;
        end
        got = 0;
      end
      ck = i_rc_mode && (ph == 1 || ph == 2);
    end
    if (!i_rst_n) begin
      oe = 0;
    end else if (i_clk_en) begin
      oe = i_rc_mode && i_master_clear_n;
    end
  end
  always @(negedge i_clock) if (cyc > 1) begin
    check(o_phases, clr ? 4'h0 : 4'h8 >> ph);
    check(o_prog_addr, pc);
    check(o_instr_valid, val);
    if (val) check(o_instr, ins);
    check(o_dmem.wr_en, wr);
    if (wr) check({o_dmem.wr_addr, o_dmem.wr_data}, wx);
    check(o_dmem.rd_en, val && ph == 1);
    if (val && ph == 1) begin
      check(o_dmem.rd_addr, ins[QPS_DADDR_W-1:0]);
    end
    check(o_osc_out_div4_clock, ck);
    check(o_osc_out_div4_clock_oe, oe);
  end
  initial begin
    seed = 3; cyc = 0; num_errors = 0; n_checks = 0;
    i_rst_n = 0; i_clk_en = 1; i_master_clear_n = 1;
    i_rc_mode = 1; i_exec = '0;
    repeat (5) @(posedge i_clock);
    #1 i_rst_n = 1;
    for (int i = 0; i < 3000; i++) begin
      @(posedge i_clock);
      #1;
      i_exec = $random(seed);
      i_exec.jump_instruction = ($random(seed) & 3) == 0;
      i_master_clear_n = (i % 700) > 5;
      i_clk_en = !i_master_clear_n || ($random(seed) & 7) != 0;
      i_rc_mode = (i / 1000) != 1;
      i_rst_n = (i != 1500);
    end
    test_done();
  end
endmodule
